/* pkg/lpf_pkg.sv */
// constants for the pixel formatter and digital video timing block
// assumes a single 200 MHz clock and a plain strobe register port
package lpf_pkg;
    localparam int CLK_MHZ = 200;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_DATA   = 12'h010;
    localparam logic [11:0] ADDR_STAT   = 12'h020;
    localparam logic [11:0] ADDR_VIDEO  = 12'h0C0;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] VIDEO_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK  = 32'h000F_FF83;
    localparam logic [31:0] VIDEO_WMASK = 32'h7FFF_FFFF;
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_DVI_BIT  = 1;
    localparam int CTRL_CSC_BIT  = 7;
    localparam int CTRL_FMT_LSB  = 8;
    localparam int CTRL_BUSW_LSB = 10;
    localparam int CTRL_OSWZ_LSB = 12;
    localparam int CTRL_ISWZ_LSB = 14;
    localparam int CTRL_MASK_LSB = 16;
    localparam int VID_ACT_LSB   = 20;
    localparam int VID_BLK_LSB   = 10;
    localparam int VID_LINES_LSB = 0;
    localparam int STAT_OVF_BIT  = 0;
    localparam int STAT_LVL_LSB  = 4;
    localparam int STAT_ST_LSB   = 8;
    localparam int STAT_LINE_LSB = 16;
    localparam logic [1:0] SWZ_NONE = 2'h0;
    localparam logic [1:0] SWZ_ALL  = 2'h1;
    localparam logic [1:0] SWZ_HWD  = 2'h2;
    localparam logic [1:0] SWZ_HBYT = 2'h3;
    localparam logic [1:0] BW16 = 2'h0;
    localparam logic [1:0] BW8  = 2'h1;
    localparam logic [1:0] BW18 = 2'h2;
    localparam logic [1:0] BW24 = 2'h3;
    localparam logic [1:0] FMT16 = 2'h0;
    localparam logic [1:0] FMT8  = 2'h1;
    localparam logic [1:0] FMT18 = 2'h2;
    localparam logic [1:0] FMT24 = 2'h3;
    localparam int FIFO_DEPTH = 8;
    localparam int SAMPLE_KHZ = 27000;
    localparam int SAMPLE_DIV = (CLK_MHZ * 1000) / SAMPLE_KHZ;
    localparam int VBLANK_LINES = 20;
    localparam logic [7:0] TRS_FF = 8'hFF;
    localparam logic [7:0] TRS_00 = 8'h00;
    localparam logic [7:0] BLANK_C = 8'h80;
    localparam logic [7:0] BLANK_Y = 8'h10;
    typedef enum logic [3:0] {
        LPF_EAV = 4'b0001,
        LPF_BLK = 4'b0010,
        LPF_SAV = 4'b0100,
        LPF_ACT = 4'b1000
    } lpf_vstate_type;
endpackage : lpf_pkg

/* hw/lpf_top.sv */
// pixel reorder, format, colour conversion and panel / video output
// assumes one clock, synchronous active-low reset, fetch stream on same clock
// Notes on behaviour
// R1: input reorder: none, all bytes, halves, bytes-in-halves
// R2: input reorder same for port and fetch
// R3: output reorder after 24-bit conversion
// R4: input reorder first, output reorder later
// R5: least significant byte or half first
// R6: with conversion, reorder acts on Y Cb Cr
// R7: bus width codes 16, 8, 18, 24
// R8: 16-bit input needs lane mask 3, C, F
// R9: 8-bit input any nonzero mask
// R10: 18-bit input needs mask F
// R11: 24-bit input needs mask 7, E, F
// R12: conversion bit turns RGB into YCbCr
// R13: send programmed active samples per line
// R14: insert programmed blanking samples per line
// R15: frame holds programmed total line count
// R16: lines framed by EAV and SAV codes
////////////////////////////////////////////////////////////////////////////////
module lpf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr;
    logic [AW:0]      rptr;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    assign level     = wptr - rptr;
    assign in_ready  = (level != (AW + 1)'(DEPTH));
    assign out_valid = (wptr != rptr);
    assign out_data  = mem[rptr[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            mem[wptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wptr <= '0;
            rptr <= '0;
        end else begin
            if (in_valid && in_ready) begin
                wptr <= wptr + 1'b1;
            end
            if (out_valid && out_ready) begin
                rptr <= rptr + 1'b1;
            end
        end
    end
endmodule : lpf_fifo
////////////////////////////////////////////////////////////////////////////////
module lpf_top
    import lpf_pkg::*;
#(
    parameter int FIFO_WORDS = FIFO_DEPTH,
    parameter int SAMPLE_CYC = SAMPLE_DIV
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        fetch_valid,
    output logic             fetch_ready,
    input  wire logic [31:0] fetch_data,
    output logic      [23:0] panel_data,
    output logic             panel_valid,
    output logic       [7:0] video_data,
    output logic             video_valid
);
    if (SAMPLE_CYC < 1 || SAMPLE_CYC > 255) begin : g_bad_div
        $error("sample divider out of range");
    end

    logic [31:0] pixel_path_control;
    logic [31:0] video_line_frame_counts;
    logic        overflow;
    logic [1:0]  iswz, oswz, bus_w, fmt;
    logic        csc_en, run, dvi;
    logic [10:0] active_sample_count;
    logic [9:0]  blank_sample_count;
    logic [9:0]  frame_line_count;

    assign run    = pixel_path_control[CTRL_RUN_BIT];
    assign dvi    = pixel_path_control[CTRL_DVI_BIT];
    assign csc_en = pixel_path_control[CTRL_CSC_BIT];
    assign fmt    = pixel_path_control[CTRL_FMT_LSB +: 2];
    assign bus_w  = pixel_path_control[CTRL_BUSW_LSB +: 2];
    assign oswz   = pixel_path_control[CTRL_OSWZ_LSB +: 2];
    assign iswz   = pixel_path_control[CTRL_ISWZ_LSB +: 2];
    assign active_sample_count = video_line_frame_counts[VID_ACT_LSB +: 11];
    assign blank_sample_count  = video_line_frame_counts[VID_BLK_LSB +: 10];
    assign frame_line_count    = video_line_frame_counts[VID_LINES_LSB +: 10];

    function automatic logic [31:0] reorder(input logic [31:0] w, input logic [1:0] m);
        unique case (m)
            SWZ_ALL:  reorder = {w[7:0], w[15:8], w[23:16], w[31:24]};
            SWZ_HWD:  reorder = {w[15:0], w[31:16]};
            SWZ_HBYT: reorder = {w[23:16], w[31:24], w[7:0], w[15:8]};
            default:  reorder = w;
        endcase
    endfunction : reorder

    ////////////////////////////////////////////////////////////////////////////
    // input side: a data port write beats the fetch stream in the same cycle
    logic        port_push, fifo_in_valid, fifo_in_ready;
    logic [31:0] fifo_in_data, fifo_out_data;
    logic        fifo_out_valid, fifo_out_ready;
    logic [$clog2(FIFO_WORDS):0] fifo_level;

    assign port_push     = reg_wr && reg_addr == ADDR_DATA;
    assign fetch_ready   = run && fifo_in_ready && !port_push;
    assign fifo_in_valid = port_push || (fetch_valid && fetch_ready);
    assign fifo_in_data  = reorder(port_push ? reg_wdata : fetch_data, iswz); // R1 R2 R4

    lpf_fifo #(.WIDTH(32), .DEPTH(FIFO_WORDS)) u_fifo (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .in_valid (fifo_in_valid),
        .in_ready (fifo_in_ready),
        .in_data  (fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data (fifo_out_data),
        .level    (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // expand to 24 bits per pixel, one pixel per word; lane mask is not used
    // since the mask legality is software's duty
    logic [23:0] pix;
    logic signed [17:0] r, g, b, ys, cbs, crs;
    logic [23:0] conv;
    logic [31:0] next_word;

    always_comb begin
        unique case (fmt)
            FMT16: pix = {fifo_out_data[15:11], fifo_out_data[15:13],
                          fifo_out_data[10:5], fifo_out_data[10:9],
                          fifo_out_data[4:0], fifo_out_data[4:2]};
            FMT8:  pix = {3{fifo_out_data[7:0]}};
            FMT18: pix = {fifo_out_data[17:12], fifo_out_data[17:16],
                          fifo_out_data[11:6], fifo_out_data[11:10],
                          fifo_out_data[5:0], fifo_out_data[5:4]};
            default: pix = fifo_out_data[23:0];
        endcase
    end

    // fixed integer coefficients, studio range; no chroma decimation here
    always_comb begin
        r   = 18'(pix[23:16]);
        g   = 18'(pix[15:8]);
        b   = 18'(pix[7:0]);
        ys  = 18'sd16 + ((18'sd66 * r + 18'sd129 * g + 18'sd25 * b + 18'sd128) >>> 8);
        cbs = 18'sd128 + ((-18'sd38 * r - 18'sd74 * g + 18'sd112 * b + 18'sd128) >>> 8);
        crs = 18'sd128 + ((18'sd112 * r - 18'sd94 * g - 18'sd18 * b + 18'sd128) >>> 8);
        conv = csc_en ? {crs[7:0], cbs[7:0], ys[7:0]} : pix; // R12
        next_word = reorder({8'h00, conv}, oswz); // R3 R4 R6
    end

    ////////////////////////////////////////////////////////////////////////////
    // beat engine: shifts each word out low part first
    logic [31:0] out_word;
    logic [1:0]  beats;
    logic [1:0]  eff_w, nbeats;
    logic        load, advance, take;
    lpf_vstate_type vst;
    logic [10:0] scnt;
    logic [9:0]  line;
    logic [7:0]  div;
    logic        tick;

    assign eff_w = dvi ? BW8 : bus_w; // video samples are byte wide
    always_comb begin
        unique case (eff_w) // R7
            BW16:    nbeats = 2'd2;
            BW8:     nbeats = 2'd3;
            default: nbeats = 2'd1;
        endcase
    end
    assign load           = run && fifo_out_valid && beats == 2'd0;
    assign fifo_out_ready = load;
    assign take           = dvi && vst == LPF_ACT && tick && beats != 2'd0;
    assign advance        = dvi ? take : beats != 2'd0;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            out_word <= '0;
            beats    <= '0;
        end else if (load) begin
            out_word <= next_word;
            beats    <= nbeats;
        end else if (advance) begin
            out_word <= (eff_w == BW16) ? out_word >> 16 : out_word >> 8; // R5
            beats    <= beats - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            panel_data  <= '0;
            panel_valid <= 1'b0;
        end else begin
            panel_valid <= !dvi && beats != 2'd0;
            unique case (eff_w) // R5 R7
                BW16:    panel_data <= {8'h00, out_word[15:0]};
                BW8:     panel_data <= {16'h0000, out_word[7:0]};
                BW18:    panel_data <= {6'h00, out_word[17:0]};
                default: panel_data <= out_word[23:0];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // video timing: EAV, blanking, SAV, active, one sample per tick
    logic last_s, is_v, is_h;
    logic [7:0] xy;

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !dvi || div == 8'(SAMPLE_CYC - 1)) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign tick = dvi && div == 8'(SAMPLE_CYC - 1);

    always_comb begin
        unique case (vst)
            LPF_BLK: last_s = scnt + 11'd1 >= {1'b0, blank_sample_count};
            LPF_ACT: last_s = scnt + 11'd1 >= active_sample_count;
            default: last_s = scnt == 11'd3;
        endcase
    end
    assign is_v = line < 10'(VBLANK_LINES);
    assign is_h = vst == LPF_EAV;
    assign xy   = {1'b1, 1'b0, is_v, is_h, is_v ^ is_h, is_h, is_v, is_v ^ is_h};

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !dvi) begin
            vst  <= LPF_EAV;
            scnt <= '0;
            line <= '0;
        end else if (tick) begin
            scnt <= last_s ? 11'd0 : scnt + 1'b1;
            if (last_s) begin
                unique case (vst)
                    LPF_EAV: vst <= LPF_BLK;
                    LPF_BLK: vst <= LPF_SAV; // R14
                    LPF_SAV: vst <= LPF_ACT; // R16
                    LPF_ACT: begin
                        vst  <= LPF_EAV; // R13
                        line <= (line + 10'd1 >= frame_line_count) ? 10'd0 : line + 1'b1; // R15
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            video_data  <= '0;
            video_valid <= 1'b0;
        end else begin
            video_valid <= tick;
            if (tick) begin
                unique case (vst)
                    LPF_BLK: video_data <= scnt[0] ? BLANK_Y : BLANK_C; // R14
                    LPF_ACT: video_data <= take ? out_word[7:0]
                                          : (scnt[0] ? BLANK_Y : BLANK_C);
                    default: video_data <= scnt == 11'd0 ? TRS_FF
                                          : scnt == 11'd3 ? xy : TRS_00; // R16
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; a full fifo drops a port write rather than stall the bus
    logic ovf_set, ovf_clr;
    assign ovf_set = port_push && !fifo_in_ready;
    assign ovf_clr = reg_wr && reg_addr == ADDR_STAT && reg_wdata[STAT_OVF_BIT];

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pixel_path_control      <= CTRL_RESET;
            video_line_frame_counts <= VIDEO_RESET;
        end else if (reg_wr && reg_addr == ADDR_CTRL) begin
            pixel_path_control <= reg_wdata & CTRL_WMASK;
        end else if (reg_wr && reg_addr == ADDR_VIDEO) begin
            video_line_frame_counts <= reg_wdata & VIDEO_WMASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            overflow <= 1'b0;
        end else if (ovf_set) begin
            overflow <= 1'b1;
        end else if (ovf_clr) begin
            overflow <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL:  reg_rdata <= pixel_path_control;
                ADDR_VIDEO: reg_rdata <= video_line_frame_counts;
                ADDR_STAT:  reg_rdata <= {6'h00, line, 4'h0, vst, 4'(fifo_level),
                                          3'h0, overflow};
                default:    reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_port_swz;
        @(posedge clk_sys) disable iff (!reset_n)
        (port_push && iswz == SWZ_ALL) |-> fifo_in_data ==
            {reg_wdata[7:0], reg_wdata[15:8], reg_wdata[23:16], reg_wdata[31:24]};
    endproperty
    a_port_swz: assert property (p_port_swz) else $error("port reorder wrong"); // R1

    property p_fetch_swz;
        @(posedge clk_sys) disable iff (!reset_n)
        (fetch_valid && fetch_ready && iswz == SWZ_HWD)
            |-> fifo_in_data == {fetch_data[15:0], fetch_data[31:16]};
    endproperty
    a_fetch_swz: assert property (p_fetch_swz) else $error("fetch reorder wrong"); // R2

    property p_out_swz;
        @(posedge clk_sys) disable iff (!reset_n)
        (load && !csc_en && fmt == FMT24 && oswz == SWZ_HBYT)
            |=> out_word == reorder({8'h00, $past(fifo_out_data[23:0])}, SWZ_HBYT);
    endproperty
    a_out_swz: assert property (p_out_swz) else $error("output reorder wrong"); // R3

    property p_half_first;
        @(posedge clk_sys) disable iff (!reset_n)
        (load && !dvi && bus_w == BW16) ##1 (!dvi && bus_w == BW16)
            |=> panel_valid && panel_data[15:0] == $past(out_word[15:0], 1);
    endproperty
    a_half_first: assert property (p_half_first) else $error("low half not first"); // R5

    property p_csc_black;
        @(posedge clk_sys) disable iff (!reset_n)
        (load && csc_en && pix == 24'h000000 && oswz == SWZ_NONE)
            |=> out_word[23:0] == 24'h808010;
    endproperty
    a_csc_black: assert property (p_csc_black) else $error("black not Y16"); // R12

    property p_act_end;
        @(posedge clk_sys) disable iff (!reset_n)
        (dvi && tick && vst == LPF_ACT && scnt + 11'd1 >= active_sample_count)
            |=> vst == LPF_EAV && scnt == 11'd0;
    endproperty
    a_act_end: assert property (p_act_end) else $error("active length wrong"); // R13

    property p_blk_end;
        @(posedge clk_sys) disable iff (!reset_n)
        (dvi && tick && vst == LPF_BLK && scnt + 11'd1 < {1'b0, blank_sample_count})
            |=> vst == LPF_BLK;
    endproperty
    a_blk_end: assert property (p_blk_end) else $error("blanking cut short"); // R14

    property p_frame_wrap;
        @(posedge clk_sys) disable iff (!reset_n)
        (dvi && tick && vst == LPF_ACT && last_s && line + 10'd1 >= frame_line_count)
            |=> line == 10'd0;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame length wrong"); // R15

    property p_eav_code;
        @(posedge clk_sys) disable iff (!reset_n)
        (tick && vst == LPF_EAV && scnt == 11'd0) |=> video_valid && video_data == TRS_FF;
    endproperty
    a_eav_code: assert property (p_eav_code) else $error("missing timing code"); // R16
endmodule : lpf_top

/* verification/lpf_panel_model.sv */
// partner model: panel and video receiver that records every beat and sample
// assumes the far side never pushes back, so nothing here drives the block
module lpf_panel_model (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [23:0] panel_data,
    input wire logic        panel_valid,
    input wire logic  [7:0] video_data,
    input wire logic        video_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] beats[$];
    logic  [7:0] samples[$];
    // beats kept in arrival order so the bench can see which half went first
    always @(posedge clk_sys) begin
        if (reset_n === 1'b1 && panel_valid === 1'b1) begin
            beats.push_back(panel_data);
        end
        if (reset_n === 1'b1 && video_valid === 1'b1) begin
            samples.push_back(video_data);
        end
    end
endmodule : lpf_panel_model

/* verification/tb_lcd_pixel_format_and_dvi_timing.sv */
// self-checking bench: register port, fetch stream, panel beats, video line
// assumes SAMPLE_CYC of 2 so a video line takes a few dozen cycles
module tb_lcd_pixel_format_and_dvi_timing
    import lpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        reset_n;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        fetch_valid;
    logic        fetch_ready;
    logic [31:0] fetch_data;
    logic [23:0] panel_data;
    logic        panel_valid;
    logic  [7:0] video_data;
    logic        video_valid;
    logic [23:0] exp_q[$];
    int          n_mismatch;
    int          num_checks;
    lpf_top #(.FIFO_WORDS(8), .SAMPLE_CYC(2)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
        .fetch_ready(fetch_ready), .fetch_data(fetch_data), .panel_data(panel_data),
        .panel_valid(panel_valid), .video_data(video_data), .video_valid(video_valid));
    lpf_panel_model model (
        .clk_sys(clk_sys), .reset_n(reset_n), .panel_data(panel_data),
        .panel_valid(panel_valid), .video_data(video_data), .video_valid(video_valid));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_fail();
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        report_and_stop();
    endtask : wait_fail
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // fetch request held until ready is seen at a rising edge
    task automatic fetch(input logic [31:0] w);
        int n;
        n = 0;
        @(posedge clk_sys);
        fetch_valid <= 1'b1;
        fetch_data  <= w;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 200) wait_fail();
        end while (fetch_ready !== 1'b1);
        fetch_valid <= 1'b0;
        fetch_data  <= ~w;
    endtask : fetch
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] swz(input logic [31:0] w, input logic [1:0] c);
        case (c)
            SWZ_ALL:  return {w[7:0], w[15:8], w[23:16], w[31:24]};
            SWZ_HWD:  return {w[15:0], w[31:16]};
            SWZ_HBYT: return {w[23:16], w[31:24], w[7:0], w[15:8]};
            default:  return w;
        endcase
    endfunction : swz
    // pixel widening by bit replication, one pixel per word
    function automatic logic [23:0] expand(input logic [31:0] w, input logic [1:0] f);
        case (f)
            FMT16:   return {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
            FMT8:    return {3{w[7:0]}};
            FMT18:   return {w[17:12], w[17:16], w[11:6], w[11:10], w[5:0], w[5:4]};
            default: return w[23:0];
        endcase
    endfunction : expand
    // 24 bpp word: input reorder, keep low 24 bits, output reorder, split low first
    task automatic push_exp(input logic [31:0] w, input logic [1:0] isw, input logic [1:0] osw,
                            input logic [1:0] bw);
        logic [31:0] t;
        logic [31:0] o;
        t = swz(w, isw);
        o = swz({8'h00, t[23:0]}, osw);
        case (bw)
            BW8: begin
                for (int i = 0; i < 3; i++) exp_q.push_back({16'h0000, o[i*8 +: 8]});
            end
            BW16: begin
                exp_q.push_back({8'h00, o[15:0]});
                exp_q.push_back({8'h00, o[31:16]});
            end
            BW18:    exp_q.push_back({6'h00, o[17:0]});
            default: exp_q.push_back(o[23:0]);
        endcase
    endtask : push_exp
    task automatic check_beats();
        int n;
        n = 0;
        while (model.beats.size() < exp_q.size()) begin
            @(posedge clk_sys);
            n++;
            if (n > 500) wait_fail();
        end
        foreach (exp_q[i]) chk({8'h00, model.beats[i]}, {8'h00, exp_q[i]});
        exp_q.delete();
        model.beats.delete();
    endtask : check_beats
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [31:0] w;
        logic  [7:0] vexp[10];
        int          n;
        vexp = '{8'hFF, 8'h00, 8'h00, 8'hB6, 8'h80, 8'h10, 8'hFF, 8'h00, 8'h00, 8'hAB};
        n_mismatch  = 0;
        num_checks  = 0;
        reset_n     = 1'b0;
        reg_addr    = 12'h000;
        reg_wdata   = 32'h0000_0000;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        fetch_valid = 1'b0;
        fetch_data  = 32'h0000_0000;
        w = $urandom(32'hF2B5C869);
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        // reset values, write masks, unmapped and write-only places
        rd(ADDR_CTRL, d);  chk(d, CTRL_RESET);
        rd(ADDR_VIDEO, d); chk(d, VIDEO_RESET);
        wr(ADDR_CTRL, 32'hFFFF_FFFC);  rd(ADDR_CTRL, d);  chk(d, 32'h000F_FF80);
        wr(ADDR_VIDEO, 32'hFFFF_FFFF); rd(ADDR_VIDEO, d); chk(d, 32'h7FFF_FFFF);
        rd(12'h030, d);   chk(d, 32'h0000_0000);
        rd(ADDR_DATA, d); chk(d, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0000);
        $display("test registers done");
        // fifo filled while stopped, ninth word refused, then drained
        wr(ADDR_CTRL, {16'h000F, SWZ_ALL, SWZ_NONE, BW16, FMT24, 8'h00});
        for (int i = 0; i < 9; i++) begin
            w = $urandom();
            wr(ADDR_DATA, w);
            if (i < 8) push_exp(w, SWZ_ALL, SWZ_NONE, BW16);
        end
        rd(ADDR_STAT, d); chk(d[7:0], 8'h81);
        wr(ADDR_STAT, 32'h0000_0001);
        rd(ADDR_STAT, d); chk(d[STAT_OVF_BIT], 1'b0);
        wr(ADDR_CTRL, {16'h000F, SWZ_ALL, SWZ_NONE, BW16, FMT24, 8'h01});
        check_beats();
        $display("test fifo done");
        // every bus width with every pair of reorders, port and fetch alternating
        for (int bw = 0; bw < 4; bw++) begin
            for (int c = 0; c < 16; c++) begin
                wr(ADDR_CTRL, {16'h000F, c[3:2], c[1:0], bw[1:0], FMT24, 8'h01});
                w = $urandom();
                if (c[0]) fetch(w);
                else wr(ADDR_DATA, w);
                push_exp(w, c[3:2], c[1:0], bw[1:0]);
                check_beats();
            end
        end
        $display("test reorder done");
        // black through the converter, plain and byte-reversed, then other formats
        wr(ADDR_CTRL, 32'h000F_0F81);
        wr(ADDR_DATA, 32'h0000_0000);
        exp_q.push_back(24'h808010);
        check_beats();
        wr(ADDR_CTRL, 32'h000F_1F81);
        wr(ADDR_DATA, 32'h0000_0000);
        exp_q.push_back(24'h808000);
        check_beats();
        for (int f = 0; f < 3; f++) begin
            w = $urandom();
            wr(ADDR_CTRL, {12'h000, f == 1 ? 4'h1 : f == 0 ? 4'h3 : 4'hF, 6'h03, f[1:0], 8'h01});
            wr(ADDR_DATA, w);
            exp_q.push_back(expand(w, f[1:0]));
            check_beats();
        end
        $display("test formats done");
        // one video line: EAV, blanking, SAV, active, next EAV
        wr(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_VIDEO, (32'd4 << VID_ACT_LSB) | (32'd2 << VID_BLK_LSB) | 32'd3);
        model.samples.delete();
        wr(ADDR_CTRL, {12'h000, 4'h3, 4'h0, BW8, 10'h003});
        n = 0;
        while (model.samples.size() < 18) begin
            @(posedge clk_sys);
            n++;
            if (n > 500) wait_fail();
        end
        for (int i = 0; i < 18; i++) begin
            if (i < 10 || i > 13) chk(model.samples[i], vexp[i % 14]);
            else chk(model.samples[i], i[0] ? 8'h10 : 8'h80);
        end
        $display("test video done");
        report_and_stop();
    end
endmodule : tb_lcd_pixel_format_and_dvi_timing
